// File: core/adc_flags_pkg.sv
// Constants shared by the converter status-flag block
package adc_flags_pkg;
  localparam int          NCHAN          = 8;
  localparam int          CHAN_W         = 3;
  localparam int          DATA_W         = 10;
  localparam int          ADR_W          = 8;
  localparam int          IRQ_W          = 3;

  // Register byte offsets
  localparam logic [7:0]  OFS_MODE       = 8'h00;
  localparam logic [7:0]  OFS_CHAN_EN    = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_LAST       = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;
  localparam logic [7:0]  OFS_CHAN_BASE  = 8'h20;

  // Field positions
  localparam int          MODE_SLEEP_BIT = 0;
  localparam int          ST_DONE_LSB    = 0;
  localparam int          ST_OVR_LSB     = 8;
  localparam int          ST_DATA_READY_BIT    = 16;
  localparam int          ST_GOVR_BIT    = 17;
  localparam int          LAST_CHAN_LSB  = 12;
  localparam int          IRQ_RESULT_BIT = 0;
  localparam int          IRQ_CHOVR_BIT  = 1;
  localparam int          IRQ_GOVR_BIT   = 2;

  // Reset values
  localparam logic [NCHAN-1:0] CHAN_EN_RST  = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [31:0]      BUS_ZERO     = 32'h0000_0000;
endpackage : adc_flags_pkg

// File: core/sticky_flags.sv
// Vector of sticky flags where a set beats a clear in the same cycle
module sticky_flags #(
  parameter int W = 8
) (
  input  wire logic         clk,    // System clock
  input  wire logic         reset,  // Synchronous reset, active high
  input  wire logic [W-1:0] set,    // Hardware set events
  input  wire logic [W-1:0] clr,    // Clear requests
  output logic      [W-1:0] q       // Flag state
);
  wire [W-1:0] next_q = set | (q & ~clr);

  // Set dominates so no event is lost
  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;  // All flags start clear [RULE17]
    else
      q <= next_q;
  end
endmodule // sticky_flags

// File: core/adc_irq.sv
// Interrupt status, mask and level output for the flag block
module adc_irq (
  input  wire logic                             clk,       // System clock
  input  wire logic                             reset,     // Synchronous reset
  input  wire logic [adc_flags_pkg::IRQ_W-1:0]  event_in,  // Event pulses
  input  wire logic [adc_flags_pkg::IRQ_W-1:0]  w1c,       // Write-one-to-clear bits
  input  wire logic                             mask_we,   // Mask write strobe
  input  wire logic [adc_flags_pkg::IRQ_W-1:0]  mask_wd,   // Mask write data
  output logic      [adc_flags_pkg::IRQ_W-1:0]  status,    // Sticky event bits
  output logic      [adc_flags_pkg::IRQ_W-1:0]  mask,      // Enable mask
  output logic                                  irq        // Level interrupt
);
  // Sticky status, events beat clears
  sticky_flags #(.W(adc_flags_pkg::IRQ_W)) u_stat (
    .clk   (clk),
    .reset (reset),
    .set   (event_in),
    .clr   (w1c),
    .q     (status)
  );

  // Mask register and registered interrupt line
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mask <= adc_flags_pkg::IRQ_MASK_RST;
      irq  <= 1'b0;
    end
    else
    begin
      if (mask_we)
        mask <= mask_wd;
      irq <= |(status & mask);
    end
  end
endmodule // adc_irq

// File: core/adc_result_status_flags.sv
// Converter result registers and status flags behind a Wishbone slave
// Behaviour
// [RULE1] Only a read of last_result clears data_ready; chan_result reads leave it alone.
// [RULE2] An end of conversion on a disabled channel never raises data_ready.
// [RULE3] An enabled end of conversion raises data_ready despite a coincident chan_result read.
// [RULE4] Every enabled end of conversion stores both results and raises data_ready.
// [RULE5] A status read beside an end of conversion still lets global_overrun set or clear.
// [RULE6] global_overrun sets when a conversion completes while data_ready is still high.
// [RULE7] A status read clears global_overrun unless a new overrun arises that cycle.
// [RULE8] A chan_result read beside an end of conversion with data_ready high sets global_overrun.
// [RULE9] Disabling another channel beside an end of conversion still raises global_overrun.
// [RULE10] chan_overrun[x] sets when channel x completes while conv_done[x] is still set.
// [RULE11] A status read clears chan_overrun even when conv_done sets again that cycle.
// [RULE12] conv_done[i] clears on a chan_result[i] read or a last_result read holding channel i.
// [RULE13] A channel disabled during its conversion never raises conv_done.
// [RULE14] A chan_result[z] read clears only conv_done[z], never another channel's flag.
// [RULE15] A sleep setting takes effect only once the next conversion completes.
// [RULE16] A hardware set and a read clear of one flag in one cycle leave the flag set.
// [RULE17] After reset every data_ready, overrun and conv_done flag is zero.
module adc_result_status_flags (
  input  wire logic                                clk,         // 25 MHz system clock
  input  wire logic                                reset,       // Sync reset, active high
  // Wishbone classic slave
  input  wire logic                                wb_cyc_i,    // Bus cycle
  input  wire logic                                wb_stb_i,    // Strobe
  input  wire logic                                wb_we_i,     // Write enable
  input  wire logic [adc_flags_pkg::ADR_W-1:0]     wb_adr_i,    // Byte address
  input  wire logic [3:0]                          wb_sel_i,    // Byte lanes
  input  wire logic [31:0]                         wb_dat_i,    // Write data
  output logic      [31:0]                         wb_dat_o,    // Read data
  output logic                                     wb_ack_o,    // Acknowledge
  // Converter core side
  input  wire logic                                eoc,         // End of conversion pulse
  input  wire logic [adc_flags_pkg::CHAN_W-1:0]    eoc_chan,    // Converted channel
  input  wire logic [adc_flags_pkg::DATA_W-1:0]    eoc_data,    // Conversion result
  output logic      [adc_flags_pkg::NCHAN-1:0]     chan_enable, // Enabled channels
  output logic                                     sleep,       // Sleep in force
  output logic                                     irq          // Interrupt level
);
  localparam int N  = adc_flags_pkg::NCHAN;
  localparam int DW = adc_flags_pkg::DATA_W;
  localparam int CW = adc_flags_pkg::CHAN_W;

  // One-hot decode of a channel number
  function automatic logic [N-1:0] onehot(input logic [CW-1:0] ch);
    logic [N-1:0] v;
    v = '0;
    v[ch] = 1'b1;
    return v;
  endfunction

  // Merge write data into an old word by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = new_w[8*b +: 8];
    return r;
  endfunction

  // Flag and result state
  logic [N-1:0]  conv_done;
  logic [N-1:0]  chan_overrun;
  logic [1:0]    glob_flags;
  logic [DW-1:0] chan_result [N];
  logic [DW-1:0] last_result;
  logic [CW-1:0] last_chan;
  logic          sleep_req;
  logic [adc_flags_pkg::IRQ_W-1:0] irq_status;
  logic [adc_flags_pkg::IRQ_W-1:0] irq_mask;
  logic          irq_line;

  wire data_ready     = glob_flags[0];
  wire global_overrun = glob_flags[1];

  // Bus request decode; each access is acted on once, in its first cycle
  wire                req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                rd      = req & ~wb_we_i;
  wire                wr      = req & wb_we_i;
  wire [7:0]          adr     = {wb_adr_i[7:2], 2'b00};
  wire                hit_mode  = (adr == adc_flags_pkg::OFS_MODE);
  wire                hit_en    = (adr == adc_flags_pkg::OFS_CHAN_EN);
  wire                hit_stat  = (adr == adc_flags_pkg::OFS_STATUS);
  wire                hit_last  = (adr == adc_flags_pkg::OFS_LAST);
  wire                hit_istat = (adr == adc_flags_pkg::OFS_IRQ_STAT);
  wire                hit_imask = (adr == adc_flags_pkg::OFS_IRQ_MASK);
  wire                hit_chan  = (adr[7:5] == adc_flags_pkg::OFS_CHAN_BASE[7:5]);
  wire [CW-1:0]       chan_idx  = adr[2+CW-1:2];

  // Read side effects
  wire                rd_status = rd & hit_stat;
  wire                rd_last   = rd & hit_last;
  wire                rd_chan   = rd & hit_chan;

  // Conversion acceptance: a disabled channel stores nothing [RULE2] [RULE13]
  wire                eoc_ok    = eoc & chan_enable[eoc_chan];
  wire [N-1:0]        eoc_hot   = eoc_ok ? onehot(eoc_chan) : '0;

  // conv_done clear terms [RULE12] [RULE14]
  wire [N-1:0]        done_clr  = (rd_chan ? onehot(chan_idx) : '0)
                                | (rd_last ? onehot(last_chan) : '0);

  // Per-channel overrun on an unread result [RULE10]
  wire [N-1:0]        ovr_set   = eoc_hot & conv_done;
  wire [N-1:0]        ovr_clr   = {N{rd_status}};           // [RULE11]

  // data_ready set on every stored result, cleared only by last_result read
  wire                data_ready_set  = eoc_ok;                   // [RULE3] [RULE4]
  wire                data_ready_clr  = rd_last;                  // [RULE1]

  // Global overrun independent of any other access in the cycle
  wire                govr_set  = eoc_ok & data_ready;      // [RULE6] [RULE8] [RULE9]
  wire                govr_clr  = rd_status;                // [RULE5] [RULE7]

  // Status word as seen before this cycle's side effects
  wire [31:0]         status_word = ({24'h0, conv_done} << adc_flags_pkg::ST_DONE_LSB)
                                  | ({24'h0, chan_overrun} << adc_flags_pkg::ST_OVR_LSB)
                                  | ({31'h0, data_ready} << adc_flags_pkg::ST_DATA_READY_BIT)
                                  | ({31'h0, global_overrun} << adc_flags_pkg::ST_GOVR_BIT);
  wire [31:0]         last_word   = {22'h0, last_result}
                                  | ({29'h0, last_chan} << adc_flags_pkg::LAST_CHAN_LSB);
  wire [31:0]         chan_word   = {22'h0, chan_result[chan_idx]};
  wire [31:0]         mode_word   = {31'h0, sleep_req};

  // Register write values, byte lanes honoured
  wire [31:0]         mode_wd   = lane_merge(mode_word, wb_dat_i, wb_sel_i);
  wire [31:0]         en_wd     = lane_merge({24'h0, chan_enable}, wb_dat_i, wb_sel_i);
  wire [31:0]         imask_wd  = lane_merge({29'h0, irq_mask}, wb_dat_i, wb_sel_i);
  wire [31:0]         w1c_wd    = lane_merge(32'h0, wb_dat_i, wb_sel_i);
  wire [adc_flags_pkg::IRQ_W-1:0] irq_w1c =
                      (wr & hit_istat) ? w1c_wd[adc_flags_pkg::IRQ_W-1:0] : '0;

  // Interrupt events
  wire [adc_flags_pkg::IRQ_W-1:0] irq_events = {govr_set, |ovr_set, data_ready_set};

  // Read multiplexer; unmapped addresses read zero
  logic [31:0] next_dat;
  always_comb
  begin
    next_dat = adc_flags_pkg::BUS_ZERO;
    if (hit_mode)
      next_dat = mode_word;
    else if (hit_en)
      next_dat = {24'h0, chan_enable};
    else if (hit_stat)
      next_dat = status_word;
    else if (hit_last)
      next_dat = last_word;
    else if (hit_istat)
      next_dat = {29'h0, irq_status};
    else if (hit_imask)
      next_dat = {29'h0, irq_mask};
    else if (hit_chan)
      next_dat = chan_word;
  end

  // Per-channel flags, set beats clear, zero after reset [RULE16] [RULE17]
  sticky_flags #(.W(N)) u_done (
    .clk   (clk),
    .reset (reset),
    .set   (eoc_hot),
    .clr   (done_clr),
    .q     (conv_done)
  );

  sticky_flags #(.W(N)) u_ovr (
    .clk   (clk),
    .reset (reset),
    .set   (ovr_set),
    .clr   (ovr_clr),
    .q     (chan_overrun)
  );

  // Global flags: bit 0 data_ready, bit 1 global_overrun [RULE16]
  sticky_flags #(.W(2)) u_glob (
    .clk   (clk),
    .reset (reset),
    .set   ({govr_set, data_ready_set}),
    .clr   ({govr_clr, data_ready_clr}),
    .q     (glob_flags)
  );

  // Event status, mask and interrupt line
  adc_irq u_irq (
    .clk      (clk),
    .reset    (reset),
    .event_in (irq_events),
    .w1c      (irq_w1c),
    .mask_we  (wr & hit_imask),
    .mask_wd  (imask_wd[adc_flags_pkg::IRQ_W-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq_line)
  );

  // Bus answer: ack one cycle after the request, data registered with it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= adc_flags_pkg::BUS_ZERO;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= next_dat;
    end
  end

  // Control registers written by software
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chan_enable <= adc_flags_pkg::CHAN_EN_RST;
      sleep_req   <= 1'b0;
    end
    else
    begin
      if (wr & hit_en)
        chan_enable <= en_wd[N-1:0];
      if (wr & hit_mode)
        sleep_req <= mode_wd[adc_flags_pkg::MODE_SLEEP_BIT];
    end
  end

  // Sleep setting only applied when a conversion completes [RULE15]
  always_ff @(posedge clk)
  begin
    if (reset)
      sleep <= 1'b0;
    else if (eoc)
      sleep <= sleep_req;
  end

  // Result storage on an accepted conversion [RULE4]
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      last_result <= '0;
      last_chan   <= '0;
    end
    else if (eoc_ok)
    begin
      last_result <= eoc_data;
      last_chan   <= eoc_chan;
    end
  end

  // Per-channel result array, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (eoc_ok)
      chan_result[eoc_chan] <= eoc_data;
  end

  // Interrupt output straight from a flip-flop
  assign irq = irq_line;
endmodule // adc_result_status_flags

// File: tb/adc_flags_properties.sv
// Port-level assertions for the converter status-flag block
module adc_flags_properties (
  input wire logic       clk,         // System clock
  input wire logic       reset,       // Sync reset
  input wire logic       wb_cyc_i,    // Bus cycle
  input wire logic       wb_stb_i,    // Strobe
  input wire logic       wb_we_i,     // Write enable
  input wire logic [7:0] wb_adr_i,    // Byte address
  input wire logic [31:0] wb_dat_o,   // Read data
  input wire logic       wb_ack_o,    // Acknowledge
  input wire logic       eoc,         // End of conversion
  input wire logic [7:0] chan_enable, // Enabled channels
  input wire logic       sleep,       // Sleep in force
  input wire logic       irq          // Interrupt level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Request taken by the slave
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_follows_req_a: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  sleep_at_eoc_a: assert property ($changed(sleep) |-> $past(eoc))
    else $error("sleep changed without conversion end");
  enable_by_write_a: assert property ($changed(chan_enable) |->
    $past(take && wb_we_i && wb_adr_i[7:2] == adc_flags_pkg::OFS_CHAN_EN[7:2]))
    else $error("channel enable changed without write");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> $past(take && !wb_we_i))
    else $error("read data changed without read");
  reset_clean_a: assert property ($fell(reset) |-> !irq && !sleep && !wb_ack_o
    && chan_enable == 8'h00) else $error("outputs not clear after reset");
  irq_has_cause_a: assert property ($rose(irq) |-> $past(eoc, 2) ||
    $past(take && wb_we_i, 2)) else $error("interrupt rose without cause");
  irq_drop_cause_a: assert property ($fell(irq) |-> $past(take && wb_we_i, 2))
    else $error("interrupt fell without write");
endmodule // adc_flags_properties

// File: tb/testbench.sv
// Self-checking bench for the converter status-flag block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] a_md = adc_flags_pkg::OFS_MODE;
  localparam logic [7:0] a_en = adc_flags_pkg::OFS_CHAN_EN;
  localparam logic [7:0] a_st = adc_flags_pkg::OFS_STATUS;
  localparam logic [7:0] a_lr = adc_flags_pkg::OFS_LAST;
  localparam logic [7:0] a_is = adc_flags_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] a_im = adc_flags_pkg::OFS_IRQ_MASK;
  localparam logic [7:0] a_cb = adc_flags_pkg::OFS_CHAN_BASE;
  logic        clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic        wb_ack_o, eoc = 1'b0, sleep, irq;
  logic [2:0]  eoc_chan = 3'h0;
  logic [9:0]  eoc_data = 10'h000;
  logic [7:0]  chan_enable;
  int          err_total = 0, n_compared = 0;

  adc_result_status_flags dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .eoc, .eoc_chan, .eoc_data, .chan_enable,
    .sleep, .irq);

  // Clock and watchdog
  initial forever #20 clk = ~clk;
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    results;
  end

  task results;
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic bus cycle, optionally with a conversion end at the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic e, input logic [2:0] ch, input logic [9:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    eoc      <= e;
    eoc_chan <= ch;
    eoc_data <= d;
    @(posedge clk);
    eoc <= 1'b0;
    // Wait for the answer; only the watchdog ends a hung access
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e = 1'b0,
                    input logic [2:0] ch = 3'h0, input logic [9:0] d = 10'h000);
    bus(1'b0, a, 32'h0, e, ch, d);
    chk($sformatf("addr_%h", a), exp, rdat);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic e = 1'b0,
                    input logic [2:0] ch = 3'h0, input logic [9:0] d = 10'h000);
    bus(1'b1, a, wd, e, ch, d);
  endtask

  task automatic conv(input logic [2:0] ch, input logic [9:0] d);
    eoc      <= 1'b1;
    eoc_chan <= ch;
    eoc_data <= d;
    @(posedge clk);
    eoc <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("sleep", 32'h0, {31'h0, sleep});
    rd(a_st, 32'h0);
    rd(a_en, 32'h0);
    rd(a_im, 32'h0);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
  endtask

  task automatic t_data_ready;
    wr(a_en, 32'hff);
    conv(3'h1, 10'h155);
    rd(a_st, 32'h0001_0002);
    rd(a_cb + 8'h04, 32'h155);
    rd(a_st, 32'h0001_0000);
    conv(3'h2, 10'h2aa);
    rd(a_st, 32'h0003_0004);
    rd(a_lr, 32'h0000_22aa);
    rd(a_st, 32'h0);
  endtask

  task automatic t_collide;
    conv(3'h3, 10'h033);
    conv(3'h5, 10'h055);
    rd(a_st, 32'h0003_0028);
    rd(a_cb + 8'h04, 32'h155, 1'b1, 3'h3, 10'h333);
    rd(a_st, 32'h0003_0828);
    rd(a_st, 32'h0001_0028);
    rd(a_cb + 8'h14, 32'h055);
    rd(a_st, 32'h0001_0008);
    rd(a_lr, 32'h0000_3333);
    rd(a_st, 32'h0);
  endtask

  task automatic t_disable;
    conv(3'h6, 10'h066);
    wr(a_en, 32'hfb, 1'b1, 3'h6, 10'h0f6);
    chk("chan_enable", 32'hfb, {24'h0, chan_enable});
    rd(a_st, 32'h0003_4040);
    rd(a_lr, 32'h0000_60f6);
    conv(3'h0, 10'h100);
    rd(a_lr, 32'h0000_0100, 1'b1, 3'h2, 10'h222);
    rd(a_st, 32'h0);
    rd(a_lr, 32'h0000_0100);
    wr(a_en, 32'hff);
  endtask

  task automatic t_ovr;
    conv(3'h7, 10'h007);
    conv(3'h7, 10'h077);
    rd(a_cb + 8'h1c, 32'h077);
    rd(a_st, 32'h0003_8000, 1'b1, 3'h7, 10'h377);
    rd(a_lr, 32'h0000_7377);
    rd(a_st, 32'h0002_0000, 1'b1, 3'h1, 10'h011);
    rd(a_st, 32'h0001_0002);
    rd(a_lr, 32'h0000_1011);
  endtask

  task automatic t_irq;
    wr(a_is, 32'h7);
    wr(a_im, 32'h1);
    rd(a_im, 32'h1);
    conv(3'h4, 10'h044);
    rd(a_is, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(a_im, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(a_im, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(a_is, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    rd(a_lr, 32'h0000_4044);
  endtask

  task automatic t_sleep;
    wr(a_md, 32'h1);
    rd(a_md, 32'h1);
    chk("sleep", 32'h0, {31'h0, sleep});
    conv(3'h5, 10'h005);
    chk("sleep", 32'h1, {31'h0, sleep});
  endtask

  // Main sequence, ending with a reset in mid-run
  initial
  begin
    t_reset;
    t_data_ready;
    t_collide;
    t_disable;
    t_ovr;
    t_irq;
    t_sleep;
    t_reset;
    results;
  end
endmodule // testbench

bind adc_result_status_flags adc_flags_properties chk_i (.clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .eoc, .chan_enable, .sleep, .irq);
